// File: rtl/tcpw_pkg.sv
// Shared constants for the timer, capture and PWM core
package tcpw_pkg;
  // Register byte addresses
  localparam logic [7:0] TSC_ADDR  = 8'h00;
  localparam logic [7:0] CNTH_ADDR = 8'h01;
  localparam logic [7:0] CNTL_ADDR = 8'h02;
  localparam logic [7:0] MODH_ADDR = 8'h03;
  localparam logic [7:0] MODL_ADDR = 8'h04;
  localparam logic [7:0] CH_BASE   = 8'h05;
  localparam logic [7:0] CH_STRIDE = 8'h03;
  // Offsets inside one channel block
  localparam logic [7:0] CSC_OFS   = 8'h00;
  localparam logic [7:0] VH_OFS    = 8'h01;
  localparam logic [7:0] VL_OFS    = 8'h02;
  // Timer status/control fields
  localparam int TOF_BIT   = 7;
  localparam int OVERFLOW_IRQ_ENABLE_BIT  = 6;
  localparam int CENTER_PWM_SELECT_BIT = 5;
  localparam int CKS_LSB   = 3;
  localparam int PS_LSB    = 0;
  // Channel status/control fields
  localparam int CHF_BIT   = 7;
  localparam int CHIE_BIT  = 6;
  localparam int MS_LSB    = 4;
  localparam int ELS_LSB   = 2;
  // Reset values and counter maximum
  localparam logic [7:0]  CSC_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] MOD_RST = 16'h0000;
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  // Counter clock source choices
  typedef enum logic [1:0] {
    CKS_OFF = 2'b00,
    CKS_BUS = 2'b01,
    CKS_FIX = 2'b10,
    CKS_EXT = 2'b11
  } tcpw_cks_t;
endpackage

// File: rtl/tcpw_core.sv
// Timer core: main counter, capture, compare and PWM channels
//
// Contract
// - Edge/level select 00 releases the channel pin from timer use.
// - Capture mode: 01 rising, 10 falling, 11 either edge.
// - Compare mode: match toggles for 01, clears for 10, sets for 11.
// - Edge PWM: 10 high-true cleared on compare, X1 low-true set.
// - Center PWM: 10 clears on up compare, X1 sets on up compare.
// - Reset clears both bytes of every channel value register.
// - Capture reads latch both bytes until the other byte is read.
// - Channel status/control write resets read and write coherency.
// - Value register writes are ignored in capture mode.
// - Halt freezes read latches; halt reads return live contents.
// - Compare/PWM writes buffer; clock off transfers on second byte.
// - Compare mode with clock loads buffer at next counter change.
// - PWM with clock loads buffer on step modulo minus one to modulo.
// - Halt writes go straight to active value, buffer left untouched.
// - One shared 16-bit counter with clock source, prescaler, modulo.
// - Center select makes all channels center PWM, counter up/down.
// - Clock select: 00 off, 01 bus, 10 fixed, 11 external.
// - Clock select resets to 00; stopping keeps counter unchanged.
// - External clock from a pin is synchronised; max bus rate/4.
// - Overflow request is static: flag and enable both set.
// - Up count wraps at terminal to 0000 and sets overflow flag.
// - Center mode sets overflow flag on turning down at modulo.
`timescale 1ns/1ns
module tcpw_core #(
  parameter int NCH     = 2,
  parameter int FIX_DIV = 2,
  parameter int EXT_CH  = 0
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [7:0]       addr,
  input  wire logic [7:0]       wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output logic      [7:0]       rdata,
  input  wire logic             debug_halt,
  input  wire logic [NCH-1:0]   ch_pin,
  output logic      [NCH-1:0]   ch_out,
  output logic      [NCH-1:0]   ch_oe,
  output logic                  overflow_irq
);

  localparam int FDW = (FIX_DIV > 1) ? $clog2(FIX_DIV) : 1;

  // Byte address of one channel register
  function automatic logic [7:0] ch_addr(input int n,
                                         input logic [7:0] ofs);
    ch_addr = 8'(int'(tcpw_pkg::CH_BASE)
                 + int'(tcpw_pkg::CH_STRIDE) * n + int'(ofs));
  endfunction

  logic                tof_reg;
  logic                overflow_irq_enable_reg;
  logic                center_pwm_select_reg;
  tcpw_pkg::tcpw_cks_t cks_reg;
  logic [2:0]          ps_reg;
  logic [15:0]         cnt_reg;
  logic [15:0]         mod_reg;
  logic                dir_reg;
  logic                tick_q_reg;
  logic [6:0]          pre_reg;
  logic [FDW-1:0]      fix_reg;
  logic                ext_s1_reg;
  logic                ext_s2_reg;
  logic                ext_s3_reg;
  logic [NCH-1:0]      pin_q_reg;
  logic [7:0]          csc_reg  [NCH];
  logic [NCH-1:0]      chf_reg;
  logic [15:0]         val_reg  [NCH];
  logic [15:0]         wbuf_reg [NCH];
  logic [NCH-1:0]      whd_reg;
  logic [NCH-1:0]      wld_reg;
  logic [NCH-1:0]      pend_reg;
  logic [15:0]         rbuf_reg [NCH];
  logic [NCH-1:0]      rlat_reg;
  logic [NCH-1:0]      rfirst_reg;

  logic [15:0]    term;
  logic           src_tick;
  logic           fix_tick;
  logic           ext_rise;
  logic [6:0]     pmask;
  logic           cnt_tick;
  logic           cnt_wr;
  logic           tof_set;
  logic [NCH-1:0] cap_m;
  logic [NCH-1:0] cmp_m;
  logic [NCH-1:0] edge_pwm_m;
  logic [NCH-1:0] cap_ev;
  logic [NCH-1:0] match;
  logic [NCH-1:0] csc_wr;
  logic [NCH-1:0] vwh;
  logic [NCH-1:0] vwl;
  logic [NCH-1:0] vrd;
  logic [NCH-1:0] load_ok;
  logic [15:0]    wnew [NCH];
  logic [7:0]     rd_mux;

  // Terminal count: modulo, or free running when modulo is zero
  assign term = (mod_reg == 16'h0000) ? tcpw_pkg::CNT_MAX : mod_reg;
  assign cnt_wr = wr && (addr == tcpw_pkg::CNTH_ADDR ||
                         addr == tcpw_pkg::CNTL_ADDR);

  // Fixed clock divider
  always_ff @(posedge sys_clk) begin
    if (rst || fix_tick) begin
      fix_reg <= '0;
    end else begin
      fix_reg <= fix_reg + 1'b1;
    end
  end
  assign fix_tick = (fix_reg == FDW'(FIX_DIV - 1));

  // External clock synchroniser
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end else begin
      ext_s1_reg <= ch_pin[EXT_CH];
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end
  assign ext_rise = ext_s2_reg && !ext_s3_reg;

  // Clock source select and prescaler output
  always_comb begin
    unique case (cks_reg)
      tcpw_pkg::CKS_OFF: src_tick = 1'b0;
      tcpw_pkg::CKS_BUS: src_tick = 1'b1;
      tcpw_pkg::CKS_FIX: src_tick = fix_tick;
      tcpw_pkg::CKS_EXT: src_tick = ext_rise;
    endcase
  end
  assign pmask    = 7'((8'h01 << ps_reg) - 8'h01);
  assign cnt_tick = src_tick && !debug_halt &&
                    ((pre_reg | ~pmask) == 7'h7f);

  // Prescaler counter
  always_ff @(posedge sys_clk) begin
    if (rst || cnt_wr) begin
      pre_reg <= 7'h00;
    end else if (src_tick && !debug_halt) begin
      pre_reg <= pre_reg + 7'h01;
    end
  end

  // Timer status/control and modulo registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      overflow_irq_enable_reg  <= 1'b0;
      center_pwm_select_reg <= 1'b0;
      cks_reg   <= tcpw_pkg::CKS_OFF;
      ps_reg    <= 3'h0;
      mod_reg   <= tcpw_pkg::MOD_RST;
    end else if (wr) begin
      if (addr == tcpw_pkg::TSC_ADDR) begin
        overflow_irq_enable_reg  <= wdata[tcpw_pkg::OVERFLOW_IRQ_ENABLE_BIT];
        center_pwm_select_reg <= wdata[tcpw_pkg::CENTER_PWM_SELECT_BIT];
        cks_reg   <= tcpw_pkg::tcpw_cks_t'(
                       wdata[tcpw_pkg::CKS_LSB +: 2]);
        ps_reg    <= wdata[tcpw_pkg::PS_LSB +: 3];
      end
      if (addr == tcpw_pkg::MODH_ADDR) begin
        mod_reg[15:8] <= wdata;
      end
      if (addr == tcpw_pkg::MODL_ADDR) begin
        mod_reg[7:0] <= wdata;
      end
    end
  end

  // Main counter, up or up/down; holds while no clock is selected
  always_ff @(posedge sys_clk) begin
    if (rst || cnt_wr) begin
      cnt_reg <= tcpw_pkg::CNT_RST;
      dir_reg <= 1'b1;
    end else if (cnt_tick) begin
      if (!center_pwm_select_reg) begin
        dir_reg <= 1'b1;
        cnt_reg <= (cnt_reg == term) ? 16'h0000 : cnt_reg + 16'h0001;
      end else if (dir_reg) begin
        if (cnt_reg == term) begin
          dir_reg <= 1'b0;
          cnt_reg <= cnt_reg - 16'h0001;
        end else begin
          cnt_reg <= cnt_reg + 16'h0001;
        end
      end else if (cnt_reg == 16'h0000) begin
        dir_reg <= 1'b1;
        cnt_reg <= 16'h0001;
      end else begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
    end
  end

  // Overflow at terminal count, going up in either mode
  assign tof_set = cnt_tick && (cnt_reg == term) &&
                   (dir_reg || !center_pwm_select_reg);

  // Overflow flag: set wins over a software clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tof_reg <= 1'b0;
    end else if (tof_set) begin
      tof_reg <= 1'b1;
    end else if (wr && addr == tcpw_pkg::TSC_ADDR &&
                 !wdata[tcpw_pkg::TOF_BIT]) begin
      tof_reg <= 1'b0;
    end
  end

  // Static overflow request
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      overflow_irq <= 1'b0;
    end else begin
      overflow_irq <= tof_reg && overflow_irq_enable_reg;
    end
  end

  // Counter change marker and pin history
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tick_q_reg <= 1'b0;
      pin_q_reg  <= '0;
    end else begin
      tick_q_reg <= cnt_tick;
      pin_q_reg  <= ch_pin;
    end
  end

  // Channel mode decode, events and write merge
  always_comb begin
    for (int n = 0; n < NCH; n++) begin
      cap_m[n]  = !center_pwm_select_reg && csc_reg[n][5:4] == 2'b00 &&
                  csc_reg[n][3:2] != 2'b00;
      cmp_m[n]  = !center_pwm_select_reg && csc_reg[n][5:4] == 2'b01;
      edge_pwm_m[n] = !center_pwm_select_reg && csc_reg[n][5];
      cap_ev[n] = cap_m[n] &&
                  ((csc_reg[n][2] && ch_pin[n] && !pin_q_reg[n]) ||
                   (csc_reg[n][3] && !ch_pin[n] && pin_q_reg[n]));
      match[n]  = tick_q_reg && (cnt_reg == val_reg[n]);
      csc_wr[n] = wr && addr == ch_addr(n, tcpw_pkg::CSC_OFS);
      vwh[n]    = wr && addr == ch_addr(n, tcpw_pkg::VH_OFS);
      vwl[n]    = wr && addr == ch_addr(n, tcpw_pkg::VL_OFS);
      vrd[n]    = rd && (addr == ch_addr(n, tcpw_pkg::VH_OFS) ||
                         addr == ch_addr(n, tcpw_pkg::VL_OFS));
      wnew[n]   = {vwh[n] ? wdata : wbuf_reg[n][15:8],
                   vwl[n] ? wdata : wbuf_reg[n][7:0]};
      load_ok[n] = cmp_m[n] ? cnt_tick
                 : (cnt_tick && dir_reg &&
                    cnt_reg == term - 16'h0001);
    end
  end

  // Channel status/control and channel flags
  always_ff @(posedge sys_clk) begin
    for (int n = 0; n < NCH; n++) begin
      if (rst) begin
        csc_reg[n] <= tcpw_pkg::CSC_RST;
        chf_reg[n] <= 1'b0;
      end else begin
        if (csc_wr[n]) begin
          csc_reg[n] <= {1'b0, wdata[6:2], 2'b00};
        end
        if (cap_ev[n] || (match[n] && !cap_m[n])) begin
          chf_reg[n] <= 1'b1;
        end else if (csc_wr[n] && !wdata[tcpw_pkg::CHF_BIT]) begin
          chf_reg[n] <= 1'b0;
        end
      end
    end
  end

  // Channel value, write buffer and transfer
  always_ff @(posedge sys_clk) begin
    for (int n = 0; n < NCH; n++) begin
      if (rst) begin
        val_reg[n]  <= tcpw_pkg::VAL_RST;
        wbuf_reg[n] <= tcpw_pkg::VAL_RST;
        whd_reg[n]  <= 1'b0;
        wld_reg[n]  <= 1'b0;
        pend_reg[n] <= 1'b0;
      end else begin
        if (cap_ev[n]) begin
          val_reg[n] <= cnt_reg;
        end else if (cap_m[n]) begin
          val_reg[n] <= val_reg[n];
        end else if (debug_halt) begin
          if (vwh[n]) begin
            val_reg[n][15:8] <= wdata;
          end
          if (vwl[n]) begin
            val_reg[n][7:0] <= wdata;
          end
        end else begin
          if (pend_reg[n] && load_ok[n]) begin
            val_reg[n]  <= wbuf_reg[n];
            pend_reg[n] <= 1'b0;
          end
          if (vwh[n] || vwl[n]) begin
            wbuf_reg[n] <= wnew[n];
            whd_reg[n]  <= whd_reg[n] || vwh[n];
            wld_reg[n]  <= wld_reg[n] || vwl[n];
            if ((whd_reg[n] || vwh[n]) && (wld_reg[n] || vwl[n])) begin
              whd_reg[n] <= 1'b0;
              wld_reg[n] <= 1'b0;
              if (cks_reg == tcpw_pkg::CKS_OFF) begin
                val_reg[n] <= wnew[n];
              end else begin
                pend_reg[n] <= 1'b1;
              end
            end
          end
        end
        if (csc_wr[n]) begin
          whd_reg[n] <= 1'b0;
          wld_reg[n] <= 1'b0;
        end
      end
    end
  end

  // Capture read coherency latches
  always_ff @(posedge sys_clk) begin
    for (int n = 0; n < NCH; n++) begin
      if (rst) begin
        rlat_reg[n]   <= 1'b0;
        rfirst_reg[n] <= 1'b0;
        rbuf_reg[n]   <= tcpw_pkg::VAL_RST;
      end else if (csc_wr[n]) begin
        rlat_reg[n] <= 1'b0;
      end else if (vrd[n] && cap_m[n] && !debug_halt) begin
        if (!rlat_reg[n]) begin
          rlat_reg[n]   <= 1'b1;
          rfirst_reg[n] <= (addr == ch_addr(n, tcpw_pkg::VL_OFS));
          rbuf_reg[n]   <= val_reg[n];
        end else if ((addr == ch_addr(n, tcpw_pkg::VL_OFS))
                     != rfirst_reg[n]) begin
          rlat_reg[n] <= 1'b0;
        end
      end
    end
  end

  // Pin drive and output level per mode
  always_ff @(posedge sys_clk) begin
    for (int n = 0; n < NCH; n++) begin
      if (rst) begin
        ch_oe[n]  <= 1'b0;
        ch_out[n] <= 1'b0;
      end else begin
        ch_oe[n] <= csc_reg[n][3:2] != 2'b00 && !cap_m[n];
        if (cmp_m[n] && match[n]) begin
          unique case (csc_reg[n][3:2])
            2'b01:   ch_out[n] <= !ch_out[n];
            2'b10:   ch_out[n] <= 1'b0;
            2'b11:   ch_out[n] <= 1'b1;
            default: ch_out[n] <= ch_out[n];
          endcase
        end else if (edge_pwm_m[n] && tick_q_reg) begin
          if (cnt_reg == val_reg[n]) begin
            ch_out[n] <= csc_reg[n][2];
          end else if (cnt_reg == 16'h0000) begin
            ch_out[n] <= !csc_reg[n][2];
          end
        end else if (center_pwm_select_reg && tick_q_reg) begin
          if (val_reg[n] == 16'h0000 || val_reg[n][15]) begin
            ch_out[n] <= csc_reg[n][2];
          end else if (cnt_reg == val_reg[n]) begin
            ch_out[n] <= dir_reg ? csc_reg[n][2] : !csc_reg[n][2];
          end
        end
      end
    end
  end

  // Read data multiplexer
  always_comb begin
    rd_mux = 8'h00;
    unique case (addr)
      tcpw_pkg::TSC_ADDR:  rd_mux = {tof_reg, overflow_irq_enable_reg, center_pwm_select_reg,
                                     cks_reg, ps_reg};
      tcpw_pkg::CNTH_ADDR: rd_mux = cnt_reg[15:8];
      tcpw_pkg::CNTL_ADDR: rd_mux = cnt_reg[7:0];
      tcpw_pkg::MODH_ADDR: rd_mux = mod_reg[15:8];
      tcpw_pkg::MODL_ADDR: rd_mux = mod_reg[7:0];
      default:             rd_mux = 8'h00;
    endcase
    for (int n = 0; n < NCH; n++) begin
      if (addr == ch_addr(n, tcpw_pkg::CSC_OFS)) begin
        rd_mux = {chf_reg[n], csc_reg[n][6:0]};
      end
      if (addr == ch_addr(n, tcpw_pkg::VH_OFS)) begin
        rd_mux = (cap_m[n] && rlat_reg[n] && !debug_halt)
               ? rbuf_reg[n][15:8] : val_reg[n][15:8];
      end
      if (addr == ch_addr(n, tcpw_pkg::VL_OFS)) begin
        rd_mux = (cap_m[n] && rlat_reg[n] && !debug_halt)
               ? rbuf_reg[n][7:0] : val_reg[n][7:0];
      end
    end
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? rd_mux : 8'h00;
    end
  end

  // Checks on channel 0 and the counter
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_release;
    csc_reg[0][3:2] == 2'b00 |=> !ch_oe[0];
  endproperty
  a_release: assert property (p_release)
    else $error("pin not released");

  property p_capture;
    cap_m[0] && csc_reg[0][3:2] == 2'b01 && ch_pin[0] && !pin_q_reg[0]
      |=> val_reg[0] == $past(cnt_reg);
  endproperty
  a_capture: assert property (p_capture)
    else $error("rising capture missed");

  property p_toggle;
    cmp_m[0] && csc_reg[0][3:2] == 2'b01 && match[0]
      |=> ch_out[0] != $past(ch_out[0]);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("compare toggle missed");

  property p_edge_pwm_clr;
    edge_pwm_m[0] && csc_reg[0][3:2] == 2'b10 && match[0] |=> !ch_out[0];
  endproperty
  a_edge_pwm_clr: assert property (p_edge_pwm_clr)
    else $error("edge pwm not cleared");

  property p_cap_nowr;
    cap_m[0] && !cap_ev[0] |=> val_reg[0] == $past(val_reg[0]);
  endproperty
  a_cap_nowr: assert property (p_cap_nowr)
    else $error("value changed in capture");

  property p_halt_lat;
    debug_halt && !csc_wr[0] |=> rlat_reg[0] == $past(rlat_reg[0]);
  endproperty
  a_halt_lat: assert property (p_halt_lat)
    else $error("latch moved in halt");

  property p_stop;
    cks_reg == tcpw_pkg::CKS_OFF && !cnt_wr
      |=> cnt_reg == $past(cnt_reg);
  endproperty
  a_stop: assert property (p_stop)
    else $error("counter moved while stopped");

  property p_irq;
    tof_reg && overflow_irq_enable_reg |=> overflow_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("overflow request lost");

  property p_wrap;
    !center_pwm_select_reg && tof_set && !cnt_wr |=> cnt_reg == 16'h0000 && tof_reg;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("up wrap wrong");

  property p_turn;
    center_pwm_select_reg && tof_set && !cnt_wr
      |=> cnt_reg == $past(term) - 16'h0001 && !dir_reg && tof_reg;
  endproperty
  a_turn: assert property (p_turn)
    else $error("center turn wrong");

  c_capture: cover property (cap_ev[0]);
  c_ovf:     cover property (tof_set ##1 overflow_irq);
  c_center_pwm:    cover property (center_pwm_select_reg && match[0] && !dir_reg);
  c_pend:    cover property (pend_reg[0] ##[1:50] !pend_reg[0]);

endmodule

// File: tb/tcpw_pin_model.sv
// Outside world at the channel pins: drives inputs, sees timer outputs
`timescale 1ns/1ns
module tcpw_pin_model #(
  parameter int NCH = 2
) (
  input  wire logic [NCH-1:0] drv_lvl,
  input  wire logic [NCH-1:0] ch_out,
  input  wire logic [NCH-1:0] ch_oe,
  output logic      [NCH-1:0] ch_pin
);
  // Pin wire: timer level while it drives, outside level once released
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      ch_pin[i] = ch_oe[i] ? ch_out[i] : drv_lvl[i];
    end
  end
endmodule

// File: tb/tb_timer_capture_pwm_core.sv
// Self-checking bench for the timer, capture and PWM core
`timescale 1ns/1ns
module tb_timer_capture_pwm_core;
  localparam logic [7:0] C1  = tcpw_pkg::CH_BASE + tcpw_pkg::CH_STRIDE;
  localparam logic [7:0] TSC = tcpw_pkg::TSC_ADDR;
  logic       sys_clk;
  logic       rst;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       debug_halt;
  logic [1:0] ch_pin;
  logic [1:0] ch_out;
  logic [1:0] ch_oe;
  logic [1:0] drv_lvl;
  logic       overflow_irq;
  int         n_mismatch;
  int         cmp_count;
  logic [7:0] rv;

  tcpw_core dut (
    .sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .debug_halt(debug_halt), .ch_pin(ch_pin),
    .ch_out(ch_out), .ch_oe(ch_oe), .overflow_irq(overflow_irq)
  );
  tcpw_pin_model #(.NCH(2)) pins (
    .drv_lvl(drv_lvl), .ch_out(ch_out), .ch_oe(ch_oe), .ch_pin(ch_pin)
  );

  // 10 MHz clock
  always #50 sys_clk = ~sys_clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One-cycle write strobe
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask

  // One-cycle read strobe, data taken one edge after the edge closing its cycle
  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    @(posedge sys_clk);
    d = rdata;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // External clock on channel 0 pin, bus rate over four
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge sys_clk) drv_lvl[0] <= 1'b1;
      cyc(2);
      drv_lvl[0] <= 1'b0;
      cyc(1);
    end
    cyc(6);
  endtask

  task automatic t_reset_values;
    rd8(C1 + tcpw_pkg::VH_OFS, rv);
    chk(rv, 8'h00);
    rd8(C1 + tcpw_pkg::VL_OFS, rv);
    chk(rv, 8'h00);
    rd8(TSC, rv);
    chk(rv[4:3], tcpw_pkg::CKS_OFF);
    rd8(8'hff, rv);
    chk(rv, 8'h00);
  endtask

  // Capture on either edge with coherent reads, external counting
  task automatic t_capture;
    wr8(TSC, 8'h00);
    wr8(C1 + tcpw_pkg::CSC_OFS, 8'h0c);
    wr8(tcpw_pkg::CNTL_ADDR, 8'h00);
    wr8(TSC, 8'h18);
    ext_pulses(5);
    rd8(tcpw_pkg::CNTL_ADDR, rv);
    chk(rv, 8'h05);
    drv_lvl[1] <= 1'b1;
    cyc(6);
    rd8(C1 + tcpw_pkg::VH_OFS, rv);
    chk(rv, 8'h00);
    ext_pulses(3);
    drv_lvl[1] <= 1'b0;
    cyc(6);
    wr8(C1 + tcpw_pkg::VL_OFS, 8'hff);
    rd8(C1 + tcpw_pkg::VL_OFS, rv);
    chk(rv, 8'h05);
    rd8(C1 + tcpw_pkg::VL_OFS, rv);
    chk(rv, 8'h08);
    chk(ch_oe[1], 1'b0);
    wr8(TSC, 8'h00);
    ext_pulses(2);
    rd8(tcpw_pkg::CNTL_ADDR, rv);
    chk(rv, 8'h08);
  endtask

  // Halt reads return live contents, latch state kept frozen
  task automatic t_halt;
    rd8(C1 + tcpw_pkg::VH_OFS, rv);
    rd8(C1 + tcpw_pkg::VH_OFS, rv);
    chk(rv, 8'h00);
    wr8(TSC, 8'h18);
    ext_pulses(1);
    debug_halt <= 1'b1;
    drv_lvl[1] <= 1'b1;
    cyc(6);
    rd8(C1 + tcpw_pkg::VL_OFS, rv);
    chk(rv, 8'h09);
    debug_halt <= 1'b0;
    cyc(2);
    rd8(C1 + tcpw_pkg::VL_OFS, rv);
    chk(rv, 8'h08);
    rd8(C1 + tcpw_pkg::VH_OFS, rv);
    ext_pulses(1);
    drv_lvl[1] <= 1'b0;
    cyc(6);
    wr8(C1 + tcpw_pkg::CSC_OFS, 8'h0c);
    rd8(C1 + tcpw_pkg::VL_OFS, rv);
    chk(rv, 8'h0a);
  endtask

  // Compare buffer: partial write, halt bypass, ticked transfer
  task automatic t_buffer;
    wr8(C1 + tcpw_pkg::CSC_OFS, 8'h1c);
    wr8(C1 + tcpw_pkg::VL_OFS, 8'h03);
    rd8(C1 + tcpw_pkg::VL_OFS, rv);
    chk(rv, 8'h02);
    debug_halt <= 1'b1;
    wr8(C1 + tcpw_pkg::VL_OFS, 8'h01);
    rd8(C1 + tcpw_pkg::VL_OFS, rv);
    chk(rv, 8'h01);
    debug_halt <= 1'b0;
    wr8(C1 + tcpw_pkg::VH_OFS, 8'h00);
    rd8(C1 + tcpw_pkg::VL_OFS, rv);
    chk(rv, 8'h03);
  endtask

  // Overflow with modulo limit, with and without the enable
  task automatic t_overflow;
    wr8(tcpw_pkg::MODH_ADDR, 8'h00);
    wr8(tcpw_pkg::MODL_ADDR, 8'h03);
    wr8(tcpw_pkg::CNTL_ADDR, 8'h00);
    wr8(TSC, 8'h08);
    cyc(8);
    rd8(TSC, rv);
    chk(rv[7], 1'b1);
    chk(overflow_irq, 1'b0);
    wr8(TSC, 8'hc8);
    cyc(2);
    chk(overflow_irq, 1'b1);
    wr8(TSC, 8'hc0);
    wr8(TSC, 8'h40);
    cyc(2);
    chk(overflow_irq, 1'b0);
  endtask

  // Compare set, clear, then pin release; clock off loads at once
  task automatic t_compare;
    wr8(TSC, 8'h00);
    wr8(C1 + tcpw_pkg::CSC_OFS, 8'h1c);
    wr8(C1 + tcpw_pkg::VH_OFS, 8'h00);
    wr8(C1 + tcpw_pkg::VL_OFS, 8'h02);
    wr8(tcpw_pkg::CNTL_ADDR, 8'h00);
    wr8(TSC, 8'h08);
    cyc(10);
    chk({ch_oe[1], ch_out[1]}, 2'b11);
    wr8(C1 + tcpw_pkg::CSC_OFS, 8'h18);
    cyc(10);
    chk({ch_oe[1], ch_out[1]}, 2'b10);
    wr8(C1 + tcpw_pkg::CSC_OFS, 8'h10);
    cyc(3);
    chk(ch_oe[1], 1'b0);
  endtask

  // PWM duty measured as high cycles over two whole periods
  task automatic t_pwm(input logic [7:0] csc, input logic [7:0] tsc,
                       input logic [7:0] v, input logic [7:0] m,
                       input int span, input int n_exp);
    int n;
    n = 0;
    wr8(TSC, tsc & 8'he7);
    wr8(C1 + tcpw_pkg::CSC_OFS, csc);
    wr8(C1 + tcpw_pkg::VH_OFS, 8'h00);
    wr8(C1 + tcpw_pkg::VL_OFS, v);
    wr8(tcpw_pkg::MODL_ADDR, m);
    wr8(tcpw_pkg::CNTL_ADDR, 8'h00);
    wr8(TSC, tsc);
    cyc(span);
    repeat (span) begin
      @(posedge sys_clk);
      #1 n += (ch_out[1] === 1'b1) ? 1 : 0;
    end
    chk(n[15:0], n_exp[15:0]);
    rd8(TSC, rv);
    chk(rv[7], 1'b1);
  endtask

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    debug_halt = 1'b0;
    drv_lvl = 2'b00;
    n_mismatch = 0;
    cmp_count = 0;
    cyc(10);
    rst <= 1'b0;
    t_reset_values();
    t_capture();
    t_halt();
    t_overflow();
    t_compare();
    t_buffer();
    t_pwm(8'h28, 8'h08, 8'h04, 8'h09, 20, 8);
    t_pwm(8'h24, 8'h08, 8'h04, 8'h09, 20, 12);
    t_pwm(8'h08, 8'h28, 8'h03, 8'h08, 32, 12);
    stop_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    stop_test();
  end
endmodule
